// *** bench/sdwl_host_model.sv ***
// Host serial port driving the loader's link pins.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module sdwl_host_model (
    output logic serialClk,
    output logic serialData,
    output logic frameSyncN,
    output logic chipSelN
);
    logic tieSel; // Three-wire mode: select stays low between frames
    // Idle: clock parked high, select and sync released
    initial begin
        {serialClk, serialData, frameSyncN, chipSelN} = 4'hB;
        tieSel = 1'b0;
    end
    // Clock pulses; also run during reset so the link side clears
    task automatic run_clk(input int n);
        repeat (n) begin
            #6 serialClk = 1'b0;
            #6 serialClk = 1'b1;
        end
    endtask
    // One frame of n bits, MSB first; one clock pulse follows the sync rise
    task automatic send(input logic [15:0] w, input int n, input logic csLow);
        chipSelN = !csLow;
        #12 frameSyncN = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            serialData = w[i];
            run_clk(1);
        end
        serialData = !serialData; // Released line shows no stale bit
        #200 frameSyncN = 1'b1; // Gap keeps the two loads apart
        run_clk(1); // Sync high at a fall clears the bit count
        #12 chipSelN = !tieSel;
        #200;
    endtask
endmodule // sdwl_host_model

// *** bench/sdwl_word_loader_asserts.sv ***
// Checker on the word loader top ports.
// Assumes the bind below; all checks run on core_clk.
`timescale 1ns/1ps
module sdwl_asserts (
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    input wire logic                     frameSyncN,
    input wire logic                     chipSelN,
    input wire logic [sdwl_pkg::CODE_BITS-1:0] dacCode,
    input wire logic                     speedFast,
    input wire logic                     powerDown,
    input wire logic                     ampEnable,
    input wire logic                     latchUpdated
);
    import sdwl_pkg::*;
    logic [3:0] fsHigh_reg;
    // Cycles since frame sync was last low, saturating
    always_ff @(posedge core_clk) begin
        fsHigh_reg <= frameSyncN ? fsHigh_reg + 4'(fsHigh_reg != 4'hF) : 4'h0;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_code; $changed(dacCode) |-> latchUpdated; endproperty
    a_code: assert property (p_code) else $error("code moved without update");
    property p_speed; $changed(speedFast) |-> latchUpdated; endproperty
    a_speed: assert property (p_speed) else $error("speed moved alone");
    property p_pwr; $changed(powerDown) |-> latchUpdated; endproperty
    a_pwr: assert property (p_pwr) else $error("power-down moved alone");
    property p_amp; powerDown |-> !ampEnable; endproperty
    a_amp: assert property (p_amp) else $error("amplifier on in power-down");
    property p_wake; $fell(powerDown) |-> ##[0:1] ampEnable; endproperty
    a_wake: assert property (p_wake) else $error("amplifier stayed off");
    property p_pulse; latchUpdated |=> !latchUpdated[*2]; endproperty
    a_pulse: assert property (p_pulse) else $error("update pulse too long");
    property p_cs; chipSelN[*8] |-> !latchUpdated; endproperty
    a_cs: assert property (p_cs) else $error("update while deselected");
    property p_fs; latchUpdated |-> fsHigh_reg <= 4'h8; endproperty
    a_fs: assert property (p_fs) else $error("update with no frame");
    property p_reset; $rose(rst_n) |-> {dacCode, speedFast, powerDown, latchUpdated} == '0; endproperty
    a_reset: assert property (p_reset) else $error("latch not cleared by reset");
    // Main scenarios reached
    c_full: cover property (latchUpdated && powerDown && speedFast);
    c_twice: cover property (latchUpdated ##[1:20] latchUpdated);
    c_zero: cover property (latchUpdated && dacCode == CODE_RESET);
endmodule // sdwl_asserts
bind sdwl_word_loader sdwl_asserts u_chk (.core_clk, .rst_n, .frameSyncN, .chipSelN, .dacCode,
    .speedFast, .powerDown, .ampEnable, .latchUpdated);

// *** bench/sdwl_word_loader_tb_top.sv ***
// Self-checking bench for the serial DAC word loader.
// Assumes the host model and bound checker are compiled first.
`timescale 1ns/1ps
module sdwl_word_loader_tb_top;
    import sdwl_pkg::*;
    logic                 core_clk, rst_n, serialClk, serialData, frameSyncN, chipSelN;
    logic [CODE_BITS-1:0] dacCode, expCode;
    logic                 speedFast, powerDown, ampEnable, latchUpdated, expFast, expDown;
    logic [15:0]          w;
    logic [15:0]          corner [5] = '{16'hFFFC, 16'h0000, 16'h9000, 16'h4FFC, 16'h2004};
    int                   badCount, checks, pulses;

    sdwl_host_model host (.serialClk, .serialData, .frameSyncN, .chipSelN);
    sdwl_word_loader dut (.core_clk, .rst_n, .serialClk, .serialData, .frameSyncN, .chipSelN,
        .dacCode, .speedFast, .powerDown, .ampEnable, .latchUpdated);

    // 50 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Update pulses seen in the current frame
    always @(posedge core_clk) if (latchUpdated === 1'b1) pulses++;

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Serial clock must run while reset is held
    task automatic do_reset();
        fork
            host.run_clk(8);
            begin
                @(negedge core_clk) rst_n = 1'b0;
                repeat (2) @(negedge core_clk);
                rst_n = 1'b1;
            end
        join
        chk("reset", {speedFast, powerDown, ampEnable, latchUpdated, 2'b0, dacCode}, 16'h0);
    endtask
    // Code field of the shift register once n bits are in (n >= 12)
    function automatic logic [9:0] code_of(input logic [15:0] v, input int n);
        logic [15:0] sr;
        sr = v >> (16 - n);
        return sr[11:2];
    endfunction
    // Upper bits of a short frame hold older content, so only full frames fix the controls
    task automatic frame(input logic [15:0] v, input int n, input logic sel);
        pulses = 0;
        host.send(v, n, sel);
        if (sel) expCode = code_of(v, n);
        chk("dacCode", 16'(dacCode), 16'(expCode));
        chk("pulses", 16'(pulses), sel ? (n == 16 ? 16'h2 : 16'h1) : 16'h0);
        if (sel && n == 16) begin
            {expFast, expDown} = v[14:13];
            chk("controls", {speedFast, powerDown, ampEnable}, {expFast, expDown, !expDown});
        end
    endtask

    // Corners, short and deselected frames, then random words
    initial begin
        {rst_n, badCount, checks, pulses, expCode} = '0;
        void'($urandom(38510));
        do_reset();
        foreach (corner[i]) frame(corner[i], 16, 1'b1);
        frame(16'h4ABC, 12, 1'b1);
        frame(16'h3FFC, 14, 1'b1);
        frame(16'h6FFC, 16, 1'b0);
        host.tieSel = 1'b1;
        frame(16'h5A5C, 16, 1'b1);
        frame(16'h0FFC, 13, 1'b1);
        host.tieSel = 1'b0;
        repeat (24) begin
            w = 16'($urandom) & 16'hFFFC;
            frame(w, ($urandom % 3 == 0) ? 12 + int'($urandom % 4) : 16, 1'(($urandom % 5) != 0));
        end
        do_reset();
        print_verdict();
    end
    // Cut a hang short; the run needs about 21 us
    initial begin
        #200000;
        badCount++;
        print_verdict();
    end
endmodule // sdwl_word_loader_tb_top

// *** design/sdwl_link_if.sv ***
// Carrier between the serial-clock receiver and the core-clock latch.
// Assumes the receiver drives every signal from serial-clock flip-flops.
`timescale 1ns/1ps
interface sdwl_link_if;
    logic [15:0] shiftWord;  // Live shift register, stable once the clock stops
    logic [15:0] heldWord;   // Word captured at the count-complete rising edge
    logic        bitsTaken;  // Level: at least one bit shifted this frame
    logic        doneToggle; // Flips once per count-completed frame

    modport link (output shiftWord, output heldWord, output bitsTaken, output doneToggle);
    modport core (input shiftWord, input heldWord, input bitsTaken, input doneToggle);
endinterface // sdwl_link_if

// *** design/sdwl_link_rx.sv ***
// Serial receiver running on the link's own clock.
// Assumes frame sync is high across at least one falling clock edge between frames.
`timescale 1ns/1ps
module sdwl_link_rx (
    input  wire logic  serialClk,
    input  wire logic  rstN,
    input  wire logic  serialData,
    input  wire logic  frameSyncN,
    input  wire logic  chipSelN,
    sdwl_link_if.link  lnk
);
    import sdwl_pkg::*;

    typedef struct packed {
        logic [1:0]  rstPipe;
        logic [15:0] shiftWord;
        logic [4:0]  bitCount;
        logic        bitsTaken;
    } sdwl_fall_s;

    typedef struct packed {
        logic [15:0] heldWord;
        logic        doneToggle;
        logic        doneSeen;
    } sdwl_rise_s;

    sdwl_fall_s fall_reg, fall_next;
    sdwl_rise_s rise_reg, rise_next;
    logic       linkRstN;

    // Reset arrives from the core domain, so it is resynchronised first
    assign linkRstN = fall_reg.rstPipe[1];

    // Falling edge: shift one bit per edge, MSB first, while selected
    always_comb begin
        fall_next = fall_reg;
        fall_next.rstPipe = {fall_reg.rstPipe[0], rstN};
        if (!linkRstN) begin
            fall_next.shiftWord = WORD_RESET;
            fall_next.bitCount  = CNT_RESET;
            fall_next.bitsTaken = 1'b0;
        end else if (frameSyncN) begin
            fall_next.bitCount  = CNT_RESET;
            fall_next.bitsTaken = 1'b0;
        end else if (!chipSelN && fall_reg.bitCount != BITS_FULL) begin
            fall_next.shiftWord = {fall_reg.shiftWord[14:0], serialData};
            fall_next.bitCount  = fall_reg.bitCount + 5'h01;
            fall_next.bitsTaken = 1'b1;
        end
    end

    always_ff @(negedge serialClk) begin
        fall_reg <= fall_next;
    end

    // Rising edge after the sixteenth fall hands the word over once
    always_comb begin
        rise_next = rise_reg;
        if (!linkRstN) begin
            rise_next.heldWord   = WORD_RESET;
            rise_next.doneToggle = 1'b0;
            rise_next.doneSeen   = 1'b0;
        end else if (fall_reg.bitCount == BITS_FULL) begin
            if (!rise_reg.doneSeen) begin
                rise_next.heldWord   = fall_reg.shiftWord;
                rise_next.doneToggle = ~rise_reg.doneToggle;
                rise_next.doneSeen   = 1'b1;
            end
        end else begin
            rise_next.doneSeen = 1'b0;
        end
    end

    always_ff @(posedge serialClk) begin
        rise_reg <= rise_next;
    end

    assign lnk.shiftWord  = fall_reg.shiftWord;
    assign lnk.bitsTaken  = fall_reg.bitsTaken;
    assign lnk.heldWord   = rise_reg.heldWord;
    assign lnk.doneToggle = rise_reg.doneToggle;
endmodule // sdwl_link_rx

// *** design/sdwl_pkg.sv ***
// Constants shared by the serial DAC word loader and its link receiver.
// Assumes the serial link carries one 16-bit word per frame, MSB first.
package sdwl_pkg;
    localparam int            WORD_BITS  = 16;
    localparam int            CODE_BITS  = 10;
    localparam int            CODE_MSB   = 11;
    localparam int            CODE_LSB   = 2;
    localparam int            SPEED_POS  = 14;
    localparam int            PWRDN_POS  = 13;
    localparam int            CNT_BITS   = 5;
    localparam logic [4:0]    BITS_FULL  = 5'h10;
    localparam logic [4:0]    CNT_RESET  = 5'h00;
    localparam logic [15:0]   WORD_RESET = 16'h0000;
    localparam logic [9:0]    CODE_RESET = 10'h000;
    localparam int            SYNC_STAGES = 2;
endpackage

// *** design/sdwl_word_loader.sv ***
// Top of the serial DAC word loader: DAC latch and control settings.
// Assumes a free-running core clock and a serial clock that may stop between frames.
`timescale 1ns/1ps
module sdwl_word_loader (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        serialClk,
    input  wire logic        serialData,
    input  wire logic        frameSyncN,
    input  wire logic        chipSelN,
    output logic [sdwl_pkg::CODE_BITS-1:0] dacCode,
    output logic             speedFast,
    output logic             powerDown,
    output logic             ampEnable,
    output logic             latchUpdated
);
    import sdwl_pkg::*;

    typedef struct packed {
        logic       fsMeta;
        logic       fsSync;
        logic       fsPrev;
        logic       tkMeta;
        logic       tkSync;
        logic       tkHeld;
        logic       tgMeta;
        logic       tgSync;
        logic       tgPrev;
        logic [9:0] dacCode;
        logic       speedFast;
        logic       powerDown;
        logic       ampEnable;
        logic       latchUpdated;
    } sdwl_core_s;

    sdwl_core_s  state_reg, state_next;
    sdwl_link_if lnk ();

    // Receiver on the serial clock
    sdwl_link_rx u_rx (
        .serialClk  (serialClk),
        .rstN       (rst_n),
        .serialData (serialData),
        .frameSyncN (frameSyncN),
        .chipSelN   (chipSelN),
        .lnk        (lnk)
    );

    // Word pick and latch update; the shift word is read only once frame sync
    // has risen, so the receiver has stopped shifting and the bits are stable
    always_comb begin
        logic       countDone;
        logic       syncRise;
        logic [15:0] word;
        countDone  = 1'b0;
        syncRise   = 1'b0;
        word       = WORD_RESET;
        state_next = state_reg;
        state_next.fsMeta = frameSyncN;
        state_next.fsSync = state_reg.fsMeta;
        state_next.fsPrev = state_reg.fsSync;
        state_next.tkMeta = lnk.bitsTaken;
        state_next.tkSync = state_reg.tkMeta;
        state_next.tgMeta = lnk.doneToggle;
        state_next.tgSync = state_reg.tgMeta;
        state_next.tgPrev = state_reg.tgSync;
        state_next.latchUpdated = 1'b0;
        countDone = state_reg.tgSync != state_reg.tgPrev;
        // The first serial fall after the sync rise clears the link's bit flag, maybe before
        // the rise has passed its own synchroniser, so the flag is held here until used
        syncRise  = state_reg.fsSync && !state_reg.fsPrev && (state_reg.tkSync || state_reg.tkHeld);
        if (syncRise) begin
            state_next.tkHeld = 1'b0;
        end else if (!state_reg.fsSync) begin
            state_next.tkHeld = state_reg.tkHeld || state_reg.tkSync;
        end
        if (countDone) begin
            word = lnk.heldWord;
        end else if (syncRise) begin
            word = lnk.shiftWord;
        end
        if (!rst_n) begin
            state_next        = '0;
            // Sync pipeline starts at the idle pin level, so release shows no false rise
            state_next.fsMeta = 1'b1;
            state_next.fsSync = 1'b1;
            state_next.fsPrev = 1'b1;
        end else if (countDone || syncRise) begin
            // Bits 15 and 12 are don't-care, bits 1..0 are dropped
            state_next.dacCode      = word[CODE_MSB:CODE_LSB];
            state_next.speedFast    = word[SPEED_POS];
            state_next.powerDown    = word[PWRDN_POS];
            state_next.ampEnable    = !word[PWRDN_POS];
            state_next.latchUpdated = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        state_reg <= state_next;
    end

    assign dacCode      = state_reg.dacCode;
    assign speedFast    = state_reg.speedFast;
    assign powerDown    = state_reg.powerDown;
    assign ampEnable    = state_reg.ampEnable;
    assign latchUpdated = state_reg.latchUpdated;
endmodule // sdwl_word_loader
